//--- verilog/uecf_consts.svh
`ifndef UECF_CONSTS_SVH
`define UECF_CONSTS_SVH

`define UECF_EP_N 7
`define UECF_CNT_W 11
`define UECF_CNT_HI_W 2
`define UECF_SEL_W 3

`define UECF_OFF_IRQ_EN 8'h00_C2
`define UECF_OFF_EP_SEL 8'h00_C7
`define UECF_OFF_FIFO_RST 8'h00_D5
`define UECF_OFF_CNT_LO 8'h00_E2
`define UECF_OFF_CNT_HI 8'h00_E3
`define UECF_OFF_IRQ_FLAGS 8'h00_F8

`define UECF_RST_IRQ_EN 7'h00
`define UECF_RST_EP_SEL 3'h0
`define UECF_RST_FIFO_RST 7'h00
`define UECF_RST_FIFO_DONE 7'h00
`define UECF_RST_IRQ_FLAGS 7'h00
`define UECF_NO_EP 3'h7

`endif

//--- verilog/uecf_pkg.sv
`default_nettype none
package uecf_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } uecf_sfr_req_t;
endpackage
`default_nettype wire

//--- verilog/uecf_top.sv
// What this block does
// - count high bits sit in low positions
// - unused high-register bits read as zero
// - low and high registers form packet length
// - counts follow the selected endpoint number
// - fifo usable only after reset bit cleared
// - flag register cleared by writing zero to a bit, bit 7 zero
// - enabled endpoint event sets its flag
`include "uecf_consts.svh"
`default_nettype none
module uecf_top
  import uecf_pkg::*;
#(
  parameter int HI_W = `UECF_CNT_HI_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire uecf_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic [`UECF_EP_N-1:0][`UECF_CNT_W-1:0] ep_rx_count,
  input wire logic [`UECF_EP_N-1:0] ep_event,
  output logic [`UECF_EP_N-1:0] fifo_reset,
  output logic [`UECF_EP_N-1:0] fifo_usable,
  output logic [`UECF_EP_N-1:0] irq_flags,
  output logic [`UECF_CNT_W-1:0] received_length
);
  localparam int N = `UECF_EP_N;
  localparam int LW = 8 + HI_W;

  logic [N-1:0] fifo_rst_reg, fifo_rst_next;
  logic [N-1:0] done_reg, done_next;
  logic [N-1:0] irq_en_reg, irq_en_next;
  logic [N-1:0] flag_reg, flag_next;
  logic [`UECF_SEL_W-1:0] sel_reg, sel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [`UECF_CNT_W-1:0] len_reg, len_next;
  logic [`UECF_CNT_W-1:0] sel_cnt;
  logic [HI_W-1:0] sel_hi;
  logic [N-1:0] set_vec, clr_vec;
  logic wr_rst, wr_en, wr_sel, wr_flag;

  // endpoint 7 does not exist; its counts read as zero
  always_comb begin
    sel_cnt = '0;
    if (sel_reg != `UECF_NO_EP) begin
      sel_cnt = ep_rx_count[sel_reg];
    end
  end
  assign sel_hi = sel_cnt[8 +: HI_W];

  assign wr_rst = sfr_req.wr && (sfr_req.addr == `UECF_OFF_FIFO_RST);
  assign wr_en = sfr_req.wr && (sfr_req.addr == `UECF_OFF_IRQ_EN);
  assign wr_sel = sfr_req.wr && (sfr_req.addr == `UECF_OFF_EP_SEL);
  assign wr_flag = sfr_req.wr && (sfr_req.addr == `UECF_OFF_IRQ_FLAGS);

  // flags clear by writing zero to the bit; a same-cycle event wins
  assign set_vec = ep_event & irq_en_reg;
  assign clr_vec = wr_flag ? ~sfr_req.wdata[N-1:0] : '0;

  always_comb begin
    fifo_rst_next = fifo_rst_reg;
    irq_en_next = irq_en_reg;
    sel_next = sel_reg;
    if (wr_rst) begin
      fifo_rst_next = sfr_req.wdata[N-1:0];
    end
    if (wr_en) begin
      irq_en_next = sfr_req.wdata[N-1:0];
    end
    if (wr_sel) begin
      sel_next = sfr_req.wdata[`UECF_SEL_W-1:0];
    end
    // a fifo is released only by a set-then-clear pulse; a usb bus
    // reset is not seen here, so firmware must pulse again after it
    done_next = done_reg | (fifo_rst_reg & ~fifo_rst_next);
    flag_next = (flag_reg & ~clr_vec) | set_vec;
    // only HI_W high bits exist; the rest of the count stays zero
    len_next = '0;
    len_next[LW-1:0] = sel_cnt[LW-1:0];
  end

  always_comb begin
    rdata_next = 8'h00_00;
    if (sfr_req.rd) begin
      if (sfr_req.addr == `UECF_OFF_CNT_HI) begin
        rdata_next = 8'(sel_hi);
      end else if (sfr_req.addr == `UECF_OFF_CNT_LO) begin
        rdata_next = sel_cnt[7:0];
      end else if (sfr_req.addr == `UECF_OFF_IRQ_FLAGS) begin
        rdata_next = {1'b0, flag_reg};
      end else if (sfr_req.addr == `UECF_OFF_FIFO_RST) begin
        rdata_next = {1'b0, fifo_rst_reg};
      end else if (sfr_req.addr == `UECF_OFF_IRQ_EN) begin
        rdata_next = {1'b0, irq_en_reg};
      end else if (sfr_req.addr == `UECF_OFF_EP_SEL) begin
        rdata_next = 8'(sel_reg);
      end else begin
        rdata_next = 8'h00_00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fifo_rst_reg <= `UECF_RST_FIFO_RST;
      done_reg <= `UECF_RST_FIFO_DONE;
      irq_en_reg <= `UECF_RST_IRQ_EN;
      flag_reg <= `UECF_RST_IRQ_FLAGS;
      sel_reg <= `UECF_RST_EP_SEL;
      rdata_reg <= 8'h00_00;
      len_reg <= '0;
    end else begin
      fifo_rst_reg <= fifo_rst_next;
      done_reg <= done_next;
      irq_en_reg <= irq_en_next;
      flag_reg <= flag_next;
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      len_reg <= len_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign fifo_reset = fifo_rst_reg;
  // a fifo held in reset, or never pulsed since hardware reset,
  // must not be touched by the engine
  assign fifo_usable = done_reg & ~fifo_rst_reg;
  assign irq_flags = flag_reg;
  assign received_length = len_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_cnt_hi_val;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_CNT_HI |=> sfr_rdata[HI_W-1:0] == $past(sel_hi);
  endproperty
  a_cnt_hi_val: assert property (p_cnt_hi_val) else $error("count high bits wrong");

  property p_cnt_hi_zero;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_CNT_HI |=> sfr_rdata[7:HI_W] == '0;
  endproperty
  a_cnt_hi_zero: assert property (p_cnt_hi_zero) else $error("unused count bits not zero");

  property p_len_pair;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_CNT_LO |=> sfr_rdata == received_length[7:0];
  endproperty
  a_len_pair: assert property (p_len_pair) else $error("low byte and length disagree");

  property p_no_ep;
    sel_reg == `UECF_NO_EP |=> received_length == '0;
  endproperty
  a_no_ep: assert property (p_no_ep) else $error("absent endpoint gave a count");

  property p_rst_write;
    wr_rst |=> fifo_reset == $past(sfr_req.wdata[N-1:0]) && (fifo_usable & fifo_reset) == '0;
  endproperty
  a_rst_write: assert property (p_rst_write) else $error("fifo reset write not taken");

  property p_flag_read;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_IRQ_FLAGS |=>
      sfr_rdata == {1'b0, $past(flag_reg)};
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag register read wrong");

  property p_flag_set;
    set_vec != '0 |=> (flag_reg & $past(set_vec)) == $past(set_vec);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("enabled event lost");

  property p_flag_cause;
    1'b1 |=> (flag_reg & ~$past(flag_reg) & ~$past(set_vec)) == '0;
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set without event");

  property p_usable_held;
    (fifo_usable & fifo_reset) == '0;
  endproperty
  a_usable_held: assert property (p_usable_held) else $error("held fifo usable");

  property p_usable_cause;
    1'b1 |=>
      (fifo_usable & ~$past(fifo_usable) & ~($past(fifo_reset) & ~fifo_reset)) == '0;
  endproperty
  a_usable_cause: assert property (p_usable_cause) else $error("usable without clear");

  property p_len_follow;
    sel_reg != `UECF_NO_EP |=>
      received_length[LW-1:0] == $past(ep_rx_count[sel_reg][LW-1:0]);
  endproperty
  a_len_follow: assert property (p_len_follow) else $error("length not of selected ep");

  property p_flag_clear;
    wr_flag |=> (flag_reg & $past(clr_vec & ~set_vec)) == '0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear not taken");

  property p_sel_read;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_EP_SEL |=> sfr_rdata == 8'($past(sel_reg));
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read wrong");

  // read data is a one-cycle answer; zero between reads
  property p_rdata_idle;
    !sfr_req.rd |=> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

  property p_en_read;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_IRQ_EN |=>
      sfr_rdata == {1'b0, $past(irq_en_reg)};
  endproperty
  a_en_read: assert property (p_en_read) else $error("enable register read wrong");

  property p_rst_read;
    sfr_req.rd && sfr_req.addr == `UECF_OFF_FIFO_RST |=>
      sfr_rdata == {1'b0, $past(fifo_reset)};
  endproperty
  a_rst_read: assert property (p_rst_read) else $error("fifo reset read wrong");

  c_set_clear: cover property (wr_flag && set_vec != '0);
  c_reset_done: cover property ($fell(fifo_reset[0]) && fifo_usable[0]);
  c_no_ep: cover property (sel_reg == `UECF_NO_EP ##1 received_length == '0);
  c_fifo_cycle: cover property (wr_rst && sfr_req.wdata[0] ##[1:20] wr_rst && !sfr_req.wdata[0]);
  c_hi_read: cover property (sfr_req.rd && sfr_req.addr == `UECF_OFF_CNT_HI && sel_hi != '0);
endmodule
`default_nettype wire

//--- verif/uecf_engine_model.sv
`default_nettype none
module uecf_engine_model (
  input wire logic [10:0] base,
  input wire logic [6:0] fire,
  output logic [6:0][10:0] ep_rx_count,
  output logic [6:0] ep_event
);
  timeunit 1ns;
  timeprecision 1ps;
  // distinct count per endpoint so a wrong select shows
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      ep_rx_count[i] = base + 11'h0c3 * 11'(i);
    end
  end
  assign ep_event = fire;
endmodule
`default_nettype wire

//--- verif/usb_endpoint_count_and_fifo_reset_test.sv
`include "uecf_consts.svh"
`default_nettype none
module usb_endpoint_count_and_fifo_reset_test import uecf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic sys_rst;
  uecf_sfr_req_t req;
  logic [7:0] rdata;
  logic [10:0] base;
  logic [6:0] fire;
  logic [6:0][10:0] cnt;
  logic [6:0] ev;
  logic [6:0] frst;
  logic [6:0] fuse;
  logic [6:0] flags;
  logic [10:0] len;
  logic [10:0] c;
  int fail_count;
  int samples_checked;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  uecf_engine_model i_eng (.base(base), .fire(fire), .ep_rx_count(cnt), .ep_event(ev));
  uecf_top i_dut (.clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rdata),
    .ep_rx_count(cnt), .ep_event(ev), .fifo_reset(frst), .fifo_usable(fuse),
    .irq_flags(flags), .received_length(len));
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // a read is compared in the one cycle its data stands
  task automatic acc(logic [7:0] a, logic w, logic [7:0] d, logic [7:0] e);
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge clk);
    req = '0;
    if (!w) chk("sfr_rdata", 11'(e), 11'(rdata));
    @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    fail_count = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    req = '0;
    base = 11'h5a3;
    fire = 7'h00;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    chk("fifo_usable", 11'h000, 11'(fuse));
    acc(`UECF_OFF_FIFO_RST, 1'b1, 8'h7f, 8'h00);
    chk("fifo_reset", 11'h07f, 11'(frst));
    chk("fifo_usable", 11'h000, 11'(fuse));
    acc(`UECF_OFF_FIFO_RST, 1'b0, 8'h00, 8'h7f);
    acc(`UECF_OFF_FIFO_RST, 1'b1, 8'h00, 8'h00);
    chk("fifo_usable", 11'h07f, 11'(fuse));
    acc(`UECF_OFF_IRQ_FLAGS, 1'b0, 8'h00, 8'h00);
    for (int i = 0; i < 7; i++) begin
      c = base + 11'h0c3 * 11'(i);
      acc(`UECF_OFF_EP_SEL, 1'b1, 8'(i), 8'h00);
      chk("received_length", {1'b0, c[9:0]}, len);
      acc(`UECF_OFF_CNT_LO, 1'b0, 8'h00, c[7:0]);
      acc(`UECF_OFF_CNT_HI, 1'b0, 8'h00, {6'h00, c[9:8]});
    end
    acc(`UECF_OFF_EP_SEL, 1'b1, 8'h07, 8'h00);
    chk("received_length", 11'h000, len);
    acc(`UECF_OFF_IRQ_EN, 1'b1, 8'h55, 8'h00);
    fire = 7'h7f;
    @(negedge clk);
    fire = 7'h00;
    chk("irq_flags", 11'h055, 11'(flags));
    acc(`UECF_OFF_IRQ_FLAGS, 1'b0, 8'h00, 8'h55);
    acc(`UECF_OFF_IRQ_FLAGS, 1'b1, 8'h54, 8'h00);
    chk("irq_flags", 11'h054, 11'(flags));
    acc(`UECF_OFF_IRQ_FLAGS, 1'b1, 8'h00, 8'h00);
    acc(`UECF_OFF_IRQ_FLAGS, 1'b0, 8'h00, 8'h00);
    // event and clear in one cycle: the event must win
    fire = 7'h01;
    req = '{addr: `UECF_OFF_IRQ_FLAGS, wr: 1'b1, rd: 1'b0, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    fire = 7'h00;
    chk("irq_flags", 11'h001, 11'(flags));
    // second hardware reset in mid-run: fifos must be pulsed again
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("fifo_usable", 11'h000, 11'(fuse));
    chk("irq_flags", 11'h000, 11'(flags));
    acc(`UECF_OFF_EP_SEL, 1'b0, 8'h00, 8'h00);
    acc(`UECF_OFF_FIFO_RST, 1'b1, 8'h7f, 8'h00);
    acc(`UECF_OFF_FIFO_RST, 1'b1, 8'h00, 8'h00);
    chk("fifo_usable", 11'h07f, 11'(fuse));
    acc(8'ha0, 1'b0, 8'h00, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
